/* verilog/dcf_core.sv */
/*
 * Buffer core: write path with masking, read path with skip and valid strobe,
 * five status flags, serial offset loading, master and partial reset.
 * Assumes write, read and serial clocks arrive as pins much slower than
 * ref_clk, so each is sampled and its rising edge detected here.
 */
// Decided for this implementation: the placing of the registers.
// Function
// R01: Almost-empty goes low when stored count is within offset; changes on read edges.
// R02: Half-full goes low at half occupancy; changes only on write edges.
// R03: Almost-full goes low at offset distance from full; changes on write edges.
// R04: Full goes low when nothing more fits; changes only on write edges.
// R05: Serial clock edges shift the serial bit into offsets while enabled.
// R06: Write and input enabled store the word and advance the write pointer.
// R07: Write enabled, input disabled advances the pointer, memory untouched.
// R08: Read and output enabled present the word with valid driven low.
// R09: Read with output disabled keeps bus high impedance, still advances pointer.
// R10: Writer issues writes in pairs; reads may be single.
// R11: Master reset clears pointers, output, flags and configuration.
// R12: A master reset must precede any access after power-up.
// R13: Partial reset clears pointers, mark and flags, keeps configuration.
// R14: Controller applies partial reset after changing configuration.
// R15: Width select captured only at end of master reset.
// R16: Width code picks 9, 12, 16, 18, 20, 24, 32 or 36 bits.
// R17: Depth is full array at x9, half to x18, quarter above.
// R18: A few locations stay unwritable as guard for the flags.
// R19: Narrow words use low bits; other inputs ignored, outputs high impedance.
// R20: Mark records the retransmit point; replay restarts reading there.
// R21: Reads are blocked while empty.
// R22: Writes are blocked while full.
// R23: Valid is active low and falls with each word shown.
// R24: Pointers cross to the other side gray coded through two stages.
`timescale 1ns/1ps
module dcf_core
   import dcf_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_DEF
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic write_clk,
   input wire logic write_enable_n,
   input wire logic input_enable_n,
   input wire logic [DATA_W-1:0] din,
   input wire logic read_clk,
   input wire logic read_enable_n,
   input wire logic output_enable_n,
   input wire logic mark_request,
   input wire logic replay_request,
   input wire logic master_reset_n,
   input wire logic partial_reset_n,
   input wire logic [2:0] port_width_select,
   input wire logic serial_config_clk,
   input wire logic serial_config_enable,
   input wire logic serial_config_in,
   output logic [DATA_W-1:0] dout,
   output logic [DATA_W-1:0] dout_oe_n,
   output logic data_valid_n,
   output logic empty_flag_n,
   output logic almost_empty_flag_n,
   output logic half_full_flag_n,
   output logic almost_full_flag_n,
   output logic full_flag_n
);

   localparam int PW = ADDR_W + 1;

   typedef struct packed {
      dcf_pins_t s1;
      dcf_pins_t s2;
      logic wclk_d;
      logic rclk_d;
      logic sclk_d;
      logic mrst_d;
      logic [2:0] width;
      logic [OFS_W-1:0] afull_ofs;
      logic [OFS_W-1:0] aempty_ofs;
      logic [PW-1:0] wptr;
      logic [PW-1:0] rptr;
      logic [PW-1:0] mark_ptr;
      logic [PW-1:0] out_ptr;
      logic [PW-1:0] wgray;
      logic [PW-1:0] rgray;
      logic [PW-1:0] wg_s1;
      logic [PW-1:0] wg_s2;
      logic [PW-1:0] rg_s1;
      logic [PW-1:0] rg_s2;
      logic empty_n;
      logic ae_n;
      logic half_n;
      logic af_n;
      logic full_n;
      logic rd_pend;
      logic rd_show;
      logic [DATA_W-1:0] q;
      logic [DATA_W-1:0] q_oe_n;
      logic valid_n;
   } dcf_state_t;

   dcf_state_t st_reg;
   dcf_state_t st_next;

   dcf_pins_t pins;
   logic wr_ev;
   logic rd_ev;
   logic sc_ev;
   logic run;
   logic wr_go;
   logic rd_go;
   logic mem_we;
   logic [ADDR_W-1:0] mem_waddr;
   logic [ADDR_W-1:0] mem_raddr;
   logic [DATA_W-1:0] mem_wdata;
   logic [DATA_W-1:0] mem_rdata;
   logic [DATA_W-1:0] mask;
   logic [PW-1:0] cap;
   logic [PW-1:0] usable;
   logic [PW-1:0] wsync;
   logic [PW-1:0] rsync;
   logic [PW-1:0] wptr_nx;
   logic [PW-1:0] rptr_nx;
   logic [PW-1:0] wcount;
   logic [PW-1:0] rcount;
   logic [CFG_W-1:0] cfg_now;
   logic [CFG_W-1:0] cfg_shift;

   function automatic logic [PW-1:0] to_gray(input logic [PW-1:0] b);
      return b ^ (b >> 1);
   endfunction : to_gray

   function automatic logic [PW-1:0] from_gray(input logic [PW-1:0] g);
      logic [PW-1:0] b;
      b = g;
      for (int i = PW - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction : from_gray

   always_comb begin
      pins = '{wclk: write_clk, rclk: read_clk, sclk: serial_config_clk,
               wen_n: write_enable_n, in_en_n: input_enable_n, ren_n: read_enable_n,
               oe_n: output_enable_n, mark: mark_request, replay: replay_request,
               sen: serial_config_enable, si: serial_config_in,
               mrst_n: master_reset_n, prst_n: partial_reset_n,
               pws: port_width_select, din: din};
   end

   dcf_mem #(
      .DW(DATA_W),
      .AW(ADDR_W)
   ) u_mem (
      .clk(ref_clk),
      .rstn(rstn),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(mem_wdata),
      .raddr(mem_raddr),
      .rdata(mem_rdata)
   );

   always_comb begin
      st_next = st_reg;
      st_next.s1 = pins;
      st_next.s2 = st_reg.s1;
      st_next.wclk_d = st_reg.s2.wclk;
      st_next.rclk_d = st_reg.s2.rclk;
      st_next.sclk_d = st_reg.s2.sclk;
      st_next.mrst_d = st_reg.s2.mrst_n;
      wr_ev = st_reg.s2.wclk & ~st_reg.wclk_d;
      rd_ev = st_reg.s2.rclk & ~st_reg.rclk_d;
      sc_ev = st_reg.s2.sclk & ~st_reg.sclk_d;
      run = st_reg.s2.mrst_n & st_reg.s2.prst_n;
      mask = dcf_word_mask(st_reg.width); // R16
      cap = PW'(1) << (PW'(ADDR_W) - PW'(dcf_depth_shift(st_reg.width))); // R17
      usable = cap - PW'(GUARD_WORDS); // R18
      cfg_now = {st_reg.afull_ofs, st_reg.aempty_ofs};
      cfg_shift = {cfg_now[CFG_W-2:0], st_reg.s2.si};
      // Each side sees the other pointer only after two gray stages
      st_next.wgray = to_gray(st_reg.wptr); // R24
      st_next.rgray = to_gray(st_reg.rptr); // R24
      st_next.wg_s1 = st_reg.wgray;
      st_next.wg_s2 = st_reg.wg_s1;
      st_next.rg_s1 = st_reg.rgray;
      st_next.rg_s2 = st_reg.rg_s1;
      wsync = from_gray(st_reg.wg_s2); // R24
      rsync = from_gray(st_reg.rg_s2); // R24

      // Write side
      wr_go = wr_ev & ~st_reg.s2.wen_n & st_reg.full_n & run; // R22
      mem_we = wr_go & ~st_reg.s2.in_en_n; // R06 R07
      mem_waddr = ADDR_W'(st_reg.wptr & (cap - PW'(1)));
      mem_wdata = st_reg.s2.din & mask; // R19
      wptr_nx = st_reg.wptr + PW'(wr_go); // R06 R07
      wcount = wptr_nx - rsync;
      st_next.wptr = wptr_nx;
      if (wr_ev) begin
         st_next.full_n = ~(wcount >= usable); // R04 R18
         st_next.half_n = ~(wcount >= (cap >> 1)); // R02
         st_next.af_n = ~(wcount >= usable - PW'(st_reg.afull_ofs)); // R03
      end

      // Read side; replay takes the edge instead of a read
      rd_go = rd_ev & ~st_reg.s2.ren_n & st_reg.empty_n & ~st_reg.s2.replay & run; // R21
      mem_raddr = ADDR_W'(st_reg.rptr & (cap - PW'(1)));
      if (rd_ev && st_reg.s2.replay) begin
         rptr_nx = st_reg.mark_ptr; // R20
      end else begin
         rptr_nx = st_reg.rptr + PW'(rd_go); // R08 R09
      end
      rcount = wsync - rptr_nx;
      st_next.rptr = rptr_nx;
      st_next.rd_pend = rd_ev;
      st_next.rd_show = rd_go & ~st_reg.s2.oe_n;
      if (rd_go) begin
         st_next.out_ptr = st_reg.rptr;
      end
      if (rd_ev && st_reg.s2.mark) begin
         st_next.mark_ptr = st_reg.out_ptr; // R20
      end
      if (rd_ev) begin
         st_next.empty_n = (rcount != '0);
         st_next.ae_n = ~(rcount <= PW'(st_reg.aempty_ofs)); // R01
      end
      // Valid holds from one read edge to the next
      if (st_reg.rd_pend) begin
         st_next.valid_n = ~st_reg.rd_show; // R23
         if (st_reg.rd_show) begin
            st_next.q = mem_rdata & mask; // R08
         end
      end
      st_next.q_oe_n = ~(mask & {DATA_W{~st_reg.s2.oe_n}}); // R09 R19

      if (sc_ev && st_reg.s2.sen) begin
         {st_next.afull_ofs, st_next.aempty_ofs} = cfg_shift; // R05
      end

      // Either reset empties the buffer; gray copies follow so no stale count
      if (!run) begin
         st_next.wptr = '0; // R11 R13
         st_next.rptr = '0;
         st_next.mark_ptr = '0;
         st_next.out_ptr = '0;
         st_next.wgray = '0;
         st_next.rgray = '0;
         st_next.wg_s1 = '0;
         st_next.wg_s2 = '0;
         st_next.rg_s1 = '0;
         st_next.rg_s2 = '0;
         st_next.empty_n = EMPTY_RST_N;
         st_next.ae_n = AEMPTY_RST_N;
         st_next.half_n = HALF_RST_N;
         st_next.af_n = AFULL_RST_N;
         st_next.full_n = FULL_RST_N;
         st_next.rd_pend = 1'b0;
         st_next.rd_show = 1'b0;
         st_next.q = '0;
         st_next.valid_n = VALID_RST_N;
      end
      if (!st_reg.s2.mrst_n) begin
         st_next.afull_ofs = OFS_DEFAULT; // R11
         st_next.aempty_ofs = OFS_DEFAULT;
      end
      if (st_reg.s2.mrst_n && !st_reg.mrst_d) begin
         st_next.width = st_reg.s2.pws; // R15
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_reg <= '0;
         st_reg.width <= WIDTH_RESET;
         st_reg.afull_ofs <= OFS_DEFAULT;
         st_reg.aempty_ofs <= OFS_DEFAULT;
         st_reg.half_n <= HALF_RST_N;
         st_reg.af_n <= AFULL_RST_N;
         st_reg.full_n <= FULL_RST_N;
         st_reg.empty_n <= EMPTY_RST_N;
         st_reg.ae_n <= AEMPTY_RST_N;
         st_reg.valid_n <= VALID_RST_N;
         st_reg.q_oe_n <= '1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign dout = st_reg.q;
   assign dout_oe_n = st_reg.q_oe_n;
   assign data_valid_n = st_reg.valid_n;
   assign empty_flag_n = st_reg.empty_n;
   assign almost_empty_flag_n = st_reg.ae_n;
   assign half_full_flag_n = st_reg.half_n;
   assign almost_full_flag_n = st_reg.af_n;
   assign full_flag_n = st_reg.full_n;

   a_full_blocks_wr: assert property (@(posedge ref_clk) disable iff (!rstn) // R22
      (wr_ev && !st_reg.s2.wen_n && !st_reg.full_n && run)
      |-> !mem_we ##1 st_reg.wptr == $past(st_reg.wptr))
      else $error("write accepted while full");

   a_empty_blocks_rd: assert property (@(posedge ref_clk) disable iff (!rstn) // R21
      (rd_ev && !st_reg.empty_n && !st_reg.s2.replay && run)
      |=> st_reg.rptr == $past(st_reg.rptr))
      else $error("read accepted while empty");

   a_write_stores: assert property (@(posedge ref_clk) disable iff (!rstn) // R06
      (wr_go && !st_reg.s2.in_en_n)
      |-> (mem_we && mem_wdata == (st_reg.s2.din & mask))
      ##1 st_reg.wptr == $past(st_reg.wptr) + PW'(1))
      else $error("enabled write did not store and advance");

   a_write_masked: assert property (@(posedge ref_clk) disable iff (!rstn) // R07
      (wr_go && st_reg.s2.in_en_n)
      |-> !mem_we ##1 st_reg.wptr == $past(st_reg.wptr) + PW'(1))
      else $error("masked write touched memory or kept pointer");

   a_read_shows_word: assert property (@(posedge ref_clk) disable iff (!rstn) // R08 R23
      (rd_go && !st_reg.s2.oe_n && st_next.s2.mrst_n && st_next.s2.prst_n)
      |=> ##1 (!data_valid_n && dout == ($past(mem_rdata) & mask)))
      else $error("read word or valid strobe missing");

   a_read_skip: assert property (@(posedge ref_clk) disable iff (!rstn) // R09
      (rd_go && st_reg.s2.oe_n)
      |=> st_reg.rptr == $past(st_reg.rptr) + PW'(1) ##1 data_valid_n)
      else $error("skipped read misbehaved");

   a_wflags_wclk: assert property (@(posedge ref_clk) disable iff (!rstn) // R02 R03 R04
      (!wr_ev && run)
      |=> ($stable(full_flag_n) && $stable(half_full_flag_n) && $stable(almost_full_flag_n)))
      else $error("write-side flag moved without a write edge");

   a_rflags_rclk: assert property (@(posedge ref_clk) disable iff (!rstn) // R01
      (!rd_ev && run)
      |=> ($stable(almost_empty_flag_n) && $stable(empty_flag_n)))
      else $error("read-side flag moved without a read edge");

   a_serial_shift: assert property (@(posedge ref_clk) disable iff (!rstn) // R05
      (sc_ev && st_reg.s2.sen && st_reg.s2.mrst_n)
      |=> cfg_now == $past(cfg_shift))
      else $error("serial bit not shifted in");

   a_master_reset: assert property (@(posedge ref_clk) disable iff (!rstn) // R11
      !st_reg.s2.mrst_n
      |=> (st_reg.wptr == '0 && st_reg.rptr == '0 && dout == '0 && !empty_flag_n
           && full_flag_n && st_reg.aempty_ofs == OFS_DEFAULT
           && st_reg.afull_ofs == OFS_DEFAULT))
      else $error("master reset incomplete");

   a_partial_reset: assert property (@(posedge ref_clk) disable iff (!rstn) // R13
      (!st_reg.s2.prst_n && st_reg.s2.mrst_n && !(sc_ev && st_reg.s2.sen))
      |=> (st_reg.wptr == '0 && st_reg.mark_ptr == '0 && !empty_flag_n && $stable(cfg_now)))
      else $error("partial reset incomplete or lost configuration");

   a_width_latch: assert property (@(posedge ref_clk) disable iff (!rstn) // R15
      !(st_reg.s2.mrst_n && !st_reg.mrst_d) |=> $stable(st_reg.width))
      else $error("width changed outside master reset release");

   a_replay_point: assert property (@(posedge ref_clk) disable iff (!rstn) // R20
      (rd_ev && st_reg.s2.replay && run)
      |=> st_reg.rptr == $past(st_reg.mark_ptr))
      else $error("replay did not restart at mark");

endmodule : dcf_core

/* verilog/dcf_pkg.sv */
/*
 * Shared constants, pin bundle type and word-size decode for the buffer core.
 * Assumes the user of these values runs everything on one sampling clock.
 */
package dcf_pkg;

   localparam int DATA_W = 36;
   localparam int ADDR_W_DEF = 23;
   localparam int OFS_W = 10;
   localparam int CFG_W = 2 * OFS_W;
   localparam logic [OFS_W-1:0] OFS_DEFAULT = 10'h07f;
   localparam int GUARD_WORDS = 4;
   localparam logic [2:0] WIDTH_RESET = 3'h7;

   // Flag levels after any reset
   localparam logic EMPTY_RST_N = 1'b0;
   localparam logic AEMPTY_RST_N = 1'b0;
   localparam logic HALF_RST_N = 1'b1;
   localparam logic AFULL_RST_N = 1'b1;
   localparam logic FULL_RST_N = 1'b1;
   localparam logic VALID_RST_N = 1'b1;

   // One sample of every pin that enters from outside
   typedef struct packed {
      logic wclk;
      logic rclk;
      logic sclk;
      logic wen_n;
      logic in_en_n;
      logic ren_n;
      logic oe_n;
      logic mark;
      logic replay;
      logic sen;
      logic si;
      logic mrst_n;
      logic prst_n;
      logic [2:0] pws;
      logic [DATA_W-1:0] din;
   } dcf_pins_t;

   function automatic logic [DATA_W-1:0] dcf_word_mask(input logic [2:0] sel);
      unique case (sel)
         3'h0: return 36'h0_0000_01ff;
         3'h1: return 36'h0_0000_0fff;
         3'h2: return 36'h0_0000_ffff;
         3'h3: return 36'h0_0003_ffff;
         3'h4: return 36'h0_000f_ffff;
         3'h5: return 36'h0_00ff_ffff;
         3'h6: return 36'h0_ffff_ffff;
         3'h7: return 36'hf_ffff_ffff;
      endcase
   endfunction : dcf_word_mask

   // Depth is the full array at x9, half up to x18, a quarter above
   function automatic logic [1:0] dcf_depth_shift(input logic [2:0] sel);
      unique case (sel)
         3'h0: return 2'h0;
         3'h1, 3'h2, 3'h3: return 2'h1;
         3'h4, 3'h5, 3'h6, 3'h7: return 2'h2;
      endcase
   endfunction : dcf_depth_shift

endpackage : dcf_pkg

/* verilog/dcf_mem.sv */
/*
 * Simple dual-port word store with registered read data.
 * Assumes one clock for both ports; read of a word written in the same
 * cycle returns the old contents.
 */
`timescale 1ns/1ps
module dcf_mem #(
   parameter int DW = 36,
   parameter int AW = 23
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= '0;
      end else begin
         rdata <= mem[raddr];
      end
   end

endmodule : dcf_mem

/* test/dcf_peer.sv */
/*
 * Writer, reader and serial loader that stand outside the buffer core.
 * Assumes the bench calls one task at a time, after the reset sequence.
 */
`timescale 1ns/1ps
module dcf_peer
   import dcf_pkg::*;
(
   input wire logic ref_clk,
   output logic write_clk,
   output logic write_enable_n,
   output logic input_enable_n,
   output logic [DATA_W-1:0] din,
   output logic read_clk,
   output logic read_enable_n,
   output logic output_enable_n,
   output logic mark_request,
   output logic replay_request,
   output logic serial_config_clk,
   output logic serial_config_enable,
   output logic serial_config_in
);
   initial begin
      {write_clk, read_clk, serial_config_clk, serial_config_enable} = 4'h0;
      {write_enable_n, input_enable_n, read_enable_n, output_enable_n} = 4'hf;
      {mark_request, replay_request, serial_config_in} = 3'h0;
      din = 36'h0;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : cyc

   // Pins held 3 cycles each side of the edge; the core samples via 2 flops
   task automatic wr_one(input logic [DATA_W-1:0] d, input logic skip);
      write_enable_n <= 1'b0;
      input_enable_n <= skip;
      din <= d;
      cyc(3);
      write_clk <= 1'b1;
      cyc(3);
      write_clk <= 1'b0;
   endtask : wr_one

   task automatic wr_pair(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b,
         input logic skip_b);
      wr_one(a, 1'b0);
      wr_one(b, skip_b);
      write_enable_n <= 1'b1;
      din <= ~b;
      cyc(1);
   endtask : wr_pair

   task automatic rd_edge(input logic ren_n, input logic oe_n, input logic mk,
         input logic rp);
      read_enable_n <= ren_n;
      output_enable_n <= oe_n;
      mark_request <= mk;
      replay_request <= rp;
      cyc(3);
      read_clk <= 1'b1;
      cyc(3);
      read_clk <= 1'b0;
      cyc(3);
   endtask : rd_edge

   task automatic sload(input logic [CFG_W-1:0] v);
      serial_config_enable <= 1'b1;
      for (int i = CFG_W - 1; i >= 0; i--) begin
         serial_config_in <= v[i];
         cyc(3);
         serial_config_clk <= 1'b1;
         cyc(3);
         serial_config_clk <= 1'b0;
      end
      cyc(3);
      serial_config_enable <= 1'b0;
      serial_config_in <= ~v[0];
   endtask : sload
endmodule : dcf_peer

/* test/dual_clock_fifo_core_tb_top.sv */
/*
 * Self-checking bench for the buffer core with a 6-bit address store.
 * Assumes the peer model drives all writer, reader and serial pins.
 */
`timescale 1ns/1ps
module dual_clock_fifo_core_tb_top
   import dcf_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic master_reset_n;
   logic partial_reset_n;
   logic [2:0] port_width_select;
   logic write_clk, write_enable_n, input_enable_n, read_clk, read_enable_n;
   logic output_enable_n, mark_request, replay_request;
   logic serial_config_clk, serial_config_enable, serial_config_in;
   logic [DATA_W-1:0] din, dout, dout_oe_n;
   logic data_valid_n, empty_flag_n, almost_empty_flag_n;
   logic half_full_flag_n, almost_full_flag_n, full_flag_n;
   logic [5:0] fl;
   int bad_count = 0;
   int num_checks = 0;
   int wd[8] = '{9, 12, 16, 18, 20, 24, 32, 36};

   assign fl = {empty_flag_n, almost_empty_flag_n, half_full_flag_n,
                almost_full_flag_n, full_flag_n, data_valid_n};

   always #2.5 ref_clk = ~ref_clk;

   // Capacity 16 words at x36 with this address width
   dcf_core #(.ADDR_W(6)) i_dut (.ref_clk, .rstn, .write_clk, .write_enable_n,
      .input_enable_n, .din, .read_clk, .read_enable_n, .output_enable_n,
      .mark_request, .replay_request, .master_reset_n, .partial_reset_n,
      .port_width_select, .serial_config_clk, .serial_config_enable,
      .serial_config_in, .dout, .dout_oe_n, .data_valid_n, .empty_flag_n,
      .almost_empty_flag_n, .half_full_flag_n, .almost_full_flag_n, .full_flag_n);

   dcf_peer i_peer (.ref_clk, .write_clk, .write_enable_n, .input_enable_n, .din,
      .read_clk, .read_enable_n, .output_enable_n, .mark_request, .replay_request,
      .serial_config_clk, .serial_config_enable, .serial_config_in);

   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
         input string what);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // Bits: empty, almost-empty, half, almost-full, full, valid
   task automatic chkf(input logic [5:0] exp, input logic [5:0] care);
      chk({30'h0, fl & care}, {30'h0, exp}, "flags");
   endtask : chkf

   function automatic logic [DATA_W-1:0] word(input int i);
      return 36'h9_0000_0100 + 36'(i);
   endfunction : word

   task automatic master_rst(input logic [2:0] code);
      master_reset_n <= 1'b0;
      port_width_select <= code;
      i_peer.cyc(4);
      master_reset_n <= 1'b1;
      i_peer.cyc(6);
      port_width_select <= ~code;
      i_peer.cyc(4);
   endtask : master_rst

   task automatic partial_rst;
      partial_reset_n <= 1'b0;
      i_peer.cyc(4);
      partial_reset_n <= 1'b1;
      i_peer.cyc(8);
   endtask : partial_rst

   // Read with outputs on and compare the word shown
   task automatic rdc(input logic [DATA_W-1:0] exp);
      i_peer.rd_edge(1'b0, 1'b0, 1'b0, 1'b0);
      chk(dout, exp, "data");
      chkf(6'h00, 6'h01);
   endtask : rdc

   // Empty flag lags writes; one idle read edge lets it catch up
   task automatic idle_rd;
      i_peer.rd_edge(1'b1, 1'b0, 1'b0, 1'b0);
   endtask : idle_rd

   task automatic t_order;
      i_peer.wr_pair(word(0), word(1), 1'b0);
      idle_rd();
      chkf(6'h2b, 6'h3b);
      rdc(word(0));
      rdc(word(1));
      chk(dout_oe_n, 36'h0, "oe");
      i_peer.rd_edge(1'b0, 1'b0, 1'b0, 1'b0);
      chkf(6'h01, 6'h21);
   endtask : t_order

   task automatic t_reset;
      master_rst(3'h7);
      chkf(6'h0f, 6'h3f);
      chk(dout, 36'h0, "dout");
      // Output enables follow the pin, not the reset
      chk(dout_oe_n, 36'h0, "oe");
   endtask : t_reset

   task automatic t_mask;
      i_peer.wr_pair(word(2), word(3), 1'b0);
      partial_rst();
      chkf(6'h0f, 6'h3f);
      i_peer.wr_pair(word(4), word(5), 1'b1);
      idle_rd();
      rdc(word(4));
      rdc(word(3));
   endtask : t_mask

   task automatic t_skip;
      i_peer.wr_pair(word(6), word(7), 1'b0);
      idle_rd();
      i_peer.rd_edge(1'b0, 1'b1, 1'b0, 1'b0);
      chk(dout_oe_n, {DATA_W{1'b1}}, "skip oe");
      chkf(6'h01, 6'h01);
      rdc(word(7));
   endtask : t_skip

   task automatic t_fill;
      master_rst(3'h7);
      for (int p = 0; p < 6; p++) begin
         i_peer.wr_pair(word(10 + 2 * p), word(11 + 2 * p), 1'b0);
         if (p == 4) begin
            chkf(6'h02, 6'h0a);
         end
      end
      chkf(6'h00, 6'h0a);
      i_peer.wr_pair(word(90), word(91), 1'b0);
      chkf(6'h00, 6'h0a);
      idle_rd();
      for (int i = 0; i < 12; i++) begin
         rdc(word(10 + i));
      end
      i_peer.rd_edge(1'b0, 1'b0, 1'b0, 1'b0);
      chkf(6'h01, 6'h21);
   endtask : t_fill

   task automatic t_serial;
      master_rst(3'h7);
      i_peer.sload({10'h002, 10'h003});
      partial_rst();
      for (int p = 0; p < 3; p++) begin
         i_peer.wr_pair(word(p), word(p), 1'b0);
      end
      idle_rd();
      chkf(6'h14, 6'h14);
      i_peer.wr_pair(word(3), word(3), 1'b0);
      chkf(6'h04, 6'h04);
      i_peer.wr_pair(word(4), word(4), 1'b0);
      chkf(6'h02, 6'h06);
      for (int i = 0; i < 6; i++) begin
         i_peer.rd_edge(1'b0, 1'b0, 1'b0, 1'b0);
      end
      chkf(6'h10, 6'h10);
      i_peer.rd_edge(1'b0, 1'b0, 1'b0, 1'b0);
      chkf(6'h00, 6'h10);
   endtask : t_serial

   task automatic t_replay;
      master_rst(3'h7);
      i_peer.wr_pair(word(20), word(21), 1'b0);
      i_peer.wr_pair(word(22), word(23), 1'b0);
      idle_rd();
      rdc(word(20));
      i_peer.rd_edge(1'b1, 1'b0, 1'b1, 1'b0);
      rdc(word(21));
      rdc(word(22));
      i_peer.rd_edge(1'b1, 1'b0, 1'b0, 1'b1);
      rdc(word(20));
   endtask : t_replay

   task automatic t_width;
      logic [DATA_W-1:0] m;
      for (int c = 0; c < 8; c++) begin
         master_rst(3'(c));
         m = {DATA_W{1'b1}} >> (DATA_W - wd[c]);
         i_peer.wr_pair({DATA_W{1'b1}}, {DATA_W{1'b1}}, 1'b0);
         idle_rd();
         i_peer.rd_edge(1'b0, 1'b0, 1'b0, 1'b0);
         chk(dout, m, "width data");
         chk(dout_oe_n, ~m, "width oe");
      end
   endtask : t_width

   initial begin
      // Master reset held from power-up until the first release
      master_reset_n = 1'b0;
      partial_reset_n = 1'b1;
      port_width_select = 3'h7;
      repeat (20) @(posedge ref_clk);
      rstn <= 1'b1;
      i_peer.cyc(4);
      master_rst(3'h7);
      t_order();
      t_reset();
      t_mask();
      t_skip();
      t_fill();
      t_serial();
      t_replay();
      t_width();
      complete_run();
   end

   // Cuts a hang short
   initial begin
      repeat (60000) @(posedge ref_clk);
      bad_count++;
      $display("[FAIL] %0t run did not finish", $time);
      complete_run();
   end
endmodule : dual_clock_fifo_core_tb_top
